// ### hw/ccr_regs.sv
// comparator control, mode and input-select registers with edge flags
// Functional notes
// - control bit 7 powers comparator on/off
// - bit 6 reads comparator result
// - rising flag bit 5 sticky until cleared
// - falling flag bit 4 sticky until cleared
// - bits 3:2 drive positive hysteresis code
// - bits 1:0 drive negative hysteresis code
// - mode bit 5 enables rising interrupt
// - mode bit 4 enables falling interrupt
// - mode bits 1:0 select speed versus power
// - mode bits 7:6, 3:2 read zero
// - four-bit field picks positive input
// - four-bit field picks negative input
// - disabled comparator drives raw output low at once, latched output low at the next enabled clock
// - interrupts on both edges, separately enabled
// - latched output plus clockless raw output
`timescale 1ns/100ps
module ccr_regs (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic comp_raw_in,
  output logic comp_enable,
  output logic [1:0] pos_hysteresis,
  output logic [1:0] neg_hysteresis,
  output logic [1:0] response_mode,
  output logic [3:0] pos_input_select,
  output logic [3:0] neg_input_select,
  output logic comp_latched_out,
  output logic comp_raw_out,
  output logic irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic rise_flag;
  logic fall_flag;
  logic rise_irq_enable;
  logic fall_irq_enable;
  logic sync_a;
  logic sync_b;
  logic sync_prev;
  logic next_rise_flag;
  logic next_fall_flag;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire ctrl_wr = sfr_wr && (sfr_addr == ccr_pkg::CTRL_ADDR);
  wire mode_wr = sfr_wr && (sfr_addr == ccr_pkg::MODE_ADDR);
  wire mux_wr = sfr_wr && (sfr_addr == ccr_pkg::MUX_ADDR);

  // comparator result seen by software and the edge detector
  wire comp_result = sync_b && comp_enable;
  wire rise_evt = comp_enable && sync_b && !sync_prev;
  wire fall_evt = comp_enable && !sync_b && sync_prev;

  // edge sets win over a software clear in the same cycle
  assign next_rise_flag = rise_evt | (ctrl_wr ? sfr_wdata[ccr_pkg::CTRL_RISE_BIT] : rise_flag);
  assign next_fall_flag = fall_evt | (ctrl_wr ? sfr_wdata[ccr_pkg::CTRL_FALL_BIT] : fall_flag);

  // register read images
  wire [7:0] ctrl_img = {comp_enable, comp_result, rise_flag, fall_flag,
                         pos_hysteresis, neg_hysteresis};
  wire [7:0] mode_img = {2'h0, rise_irq_enable, fall_irq_enable,
                         2'h0, response_mode};
  wire [7:0] mux_img = {neg_input_select, pos_input_select};
  wire [7:0] rd_mux = (sfr_addr == ccr_pkg::CTRL_ADDR) ? ctrl_img :
                      (sfr_addr == ccr_pkg::MODE_ADDR) ? mode_img :
                      (sfr_addr == ccr_pkg::MUX_ADDR) ? mux_img : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // outputs to the analog core and pins
  assign comp_raw_out = comp_raw_in && comp_enable;
  assign irq_req = (rise_flag && rise_irq_enable) ||
                   (fall_flag && fall_irq_enable);

  // two-stage synchroniser and edge history
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
    end else if (clk_en) begin
      sync_a <= comp_raw_in;
      sync_b <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // latched pin output follows the synchronised result
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      comp_latched_out <= 1'b0;
    end else if (clk_en) begin
      comp_latched_out <= comp_result;
    end
  end

  // control register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      comp_enable <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_EN_BIT];
      rise_flag <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_RISE_BIT];
      fall_flag <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_FALL_BIT];
      pos_hysteresis <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_HYP_LSB +: ccr_pkg::HYS_W];
      neg_hysteresis <= ccr_pkg::CTRL_RST[ccr_pkg::CTRL_HYN_LSB +: ccr_pkg::HYS_W];
    end else if (clk_en) begin
      rise_flag <= next_rise_flag;
      fall_flag <= next_fall_flag;
      if (ctrl_wr) begin
        comp_enable <= sfr_wdata[ccr_pkg::CTRL_EN_BIT];
        pos_hysteresis <= sfr_wdata[ccr_pkg::CTRL_HYP_LSB +: ccr_pkg::HYS_W];
        neg_hysteresis <= sfr_wdata[ccr_pkg::CTRL_HYN_LSB +: ccr_pkg::HYS_W];
      end
    end
  end

  // mode register, unused bits are not stored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rise_irq_enable <= ccr_pkg::MODE_RST[ccr_pkg::MODE_RIE_BIT];
      fall_irq_enable <= ccr_pkg::MODE_RST[ccr_pkg::MODE_FIE_BIT];
      response_mode <= ccr_pkg::MODE_RST[ccr_pkg::MODE_MD_LSB +: ccr_pkg::MD_W];
    end else if (clk_en && mode_wr) begin
      rise_irq_enable <= sfr_wdata[ccr_pkg::MODE_RIE_BIT];
      fall_irq_enable <= sfr_wdata[ccr_pkg::MODE_FIE_BIT];
      response_mode <= sfr_wdata[ccr_pkg::MODE_MD_LSB +: ccr_pkg::MD_W];
    end
  end

  // input select register; pin setup as analog is up to software
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pos_input_select <= ccr_pkg::MUX_RST[ccr_pkg::MUX_POS_LSB +: ccr_pkg::SEL_W];
      neg_input_select <= ccr_pkg::MUX_RST[ccr_pkg::MUX_NEG_LSB +: ccr_pkg::SEL_W];
    end else if (clk_en && mux_wr) begin
      pos_input_select <= sfr_wdata[ccr_pkg::MUX_POS_LSB +: ccr_pkg::SEL_W];
      neg_input_select <= sfr_wdata[ccr_pkg::MUX_NEG_LSB +: ccr_pkg::SEL_W];
    end
  end

  // read data, registered one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
    end else if (clk_en && sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence raw_high_seen;
    (clk_en && comp_raw_in) ##1 clk_en;
  endsequence

  sequence rise_caught;
    clk_en && rise_evt;
  endsequence

  sequence fall_caught;
    clk_en && fall_evt;
  endsequence

  enable_write_a: assert property ((clk_en && ctrl_wr) |=>
    comp_enable == $past(sfr_wdata[7]))
    else $error("enable bit did not take written value");

  result_sync_a: assert property (raw_high_seen ##0 comp_enable
    |=> sync_b && (comp_enable ? comp_result : 1'b1))
    else $error("synchronised result missed a held high input");

  rise_set_a: assert property (rise_caught |=> rise_flag [*1])
    else $error("rising edge did not set flag");

  rise_hold_a: assert property ((rise_flag && !(clk_en && ctrl_wr)) |=> rise_flag)
    else $error("rising flag dropped without a write");

  fall_set_a: assert property (fall_caught |=> fall_flag)
    else $error("falling edge did not set flag");

  fall_hold_a: assert property ((fall_flag && !(clk_en && ctrl_wr)) |=> fall_flag)
    else $error("falling flag dropped without a write");

  hyst_write_a: assert property ((clk_en && ctrl_wr) |=>
    {pos_hysteresis, neg_hysteresis} == $past(sfr_wdata[3:0]))
    else $error("hysteresis codes did not take written value");

  mode_write_a: assert property ((clk_en && mode_wr) |=>
    {rise_irq_enable, fall_irq_enable, response_mode} ==
    {$past(sfr_wdata[5:4]), $past(sfr_wdata[1:0])})
    else $error("mode register did not take written value");

  mode_zero_a: assert property ((clk_en && sfr_rd && sfr_addr == ccr_pkg::MODE_ADDR)
    |=> (sfr_rdata & ccr_pkg::MODE_UNUSED_MASK) == 8'h00)
    else $error("unused mode bits read nonzero");

  mux_write_a: assert property ((clk_en && mux_wr) |=>
    {neg_input_select, pos_input_select} == $past(sfr_wdata))
    else $error("input select did not take written value");

  // a frozen clock keeps the last latched level, so the latch is judged after an enabled cycle
  off_low_a: assert property ((clk_en && !comp_enable) ##1 !comp_enable |->
    !comp_latched_out && !comp_raw_out)
    else $error("disabled comparator output not low");

  irq_edge_a: assert property ((rise_caught ##0 rise_irq_enable && !mode_wr)
    |=> irq_req)
    else $error("enabled rising edge raised no interrupt");

endmodule

// ### hw/ccr_pkg.sv
// constants for the comparator control register bank
package ccr_pkg;
  // special-function register addresses
  localparam logic [7:0] CTRL_ADDR = 8'h9b;
  localparam logic [7:0] MODE_ADDR = 8'h9d;
  localparam logic [7:0] MUX_ADDR = 8'h9f;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] MUX_RST = 8'hff;
  // control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OUT_BIT = 6;
  localparam int CTRL_RISE_BIT = 5;
  localparam int CTRL_FALL_BIT = 4;
  localparam int CTRL_HYP_LSB = 2;
  localparam int CTRL_HYN_LSB = 0;
  // mode register fields
  localparam int MODE_RIE_BIT = 5;
  localparam int MODE_FIE_BIT = 4;
  localparam int MODE_MD_LSB = 0;
  localparam logic [7:0] MODE_UNUSED_MASK = 8'hcc;
  // input select register fields
  localparam int MUX_NEG_LSB = 4;
  localparam int MUX_POS_LSB = 0;
  // field widths
  localparam int HYS_W = 2;
  localparam int MD_W = 2;
  localparam int SEL_W = 4;
  // response mode codes
  typedef enum logic [1:0] {
    CCR_MODE_FAST = 2'h0,
    CCR_MODE_1 = 2'h1,
    CCR_MODE_2 = 2'h2,
    CCR_MODE_SLOW = 2'h3
  } ccr_mode_e;
  // hysteresis codes
  typedef enum logic [1:0] {
    CCR_HYS_OFF = 2'h0,
    CCR_HYS_5MV = 2'h1,
    CCR_HYS_10MV = 2'h2,
    CCR_HYS_20MV = 2'h3
  } ccr_hys_e;
endpackage

// ### dv/ccr_core_model.sv
// behavioural model of the analog comparator core
`timescale 1ns/100ps
module ccr_core_model (
  input wire logic comp_enable,
  input wire logic pos_above, // chosen pins are set up as analog inputs
  output logic comp_raw_in
);
  logic last_out;
  initial begin
    comp_raw_in = 1'b0;
    last_out = 1'b0;
  end
  // a powered core follows its inputs, an unpowered one gives no stable level
  always @(comp_enable, pos_above) begin
    if (comp_enable) begin
      comp_raw_in = pos_above;
    end else begin
      comp_raw_in = ~last_out;
    end
    last_out = comp_raw_in;
  end
endmodule

// ### dv/ccr_regs_tb_top.sv
// self-checking bench for the comparator control register bank
`timescale 1ns/100ps
module ccr_regs_tb_top;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic pos_above = 1'b0;
  logic [7:0] sfr_rdata;
  logic comp_raw_in, comp_enable, comp_latched_out, comp_raw_out, irq_req;
  logic [1:0] pos_hysteresis, neg_hysteresis, response_mode;
  logic [3:0] pos_input_select, neg_input_select;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  // clock generation
  always #2 clk_sys = ~clk_sys;
  ccr_regs i_ccr_regs (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .comp_raw_in(comp_raw_in), .comp_enable(comp_enable),
    .pos_hysteresis(pos_hysteresis), .neg_hysteresis(neg_hysteresis),
    .response_mode(response_mode), .pos_input_select(pos_input_select),
    .neg_input_select(neg_input_select), .comp_latched_out(comp_latched_out),
    .comp_raw_out(comp_raw_out), .irq_req(irq_req));
  ccr_core_model i_ccr_core_model (.comp_enable(comp_enable), .pos_above(pos_above),
    .comp_raw_in(comp_raw_in));
  ////////////////////////////////////////////////////////////////////////////////
  // waits n rising edges, then steps just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
  endtask
  // one-cycle read strobe, data registered at the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    chk8("sfr_rdata", exp, sfr_rdata);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    tick(20);
    sys_rst = 1'b0;
    rd(ccr_pkg::CTRL_ADDR, 8'h00);
    rd(ccr_pkg::MODE_ADDR, 8'h02);
    rd(ccr_pkg::MUX_ADDR, 8'hff);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(ccr_pkg::CTRL_ADDR, 8'h80 | 8'(3 * i + 3));
      chk8("hysteresis", 8'(3 * i + 3), {4'h0, pos_hysteresis, neg_hysteresis});
      chk1("comp_enable", 1'b1, comp_enable);
      wr(ccr_pkg::MODE_ADDR, 8'hcc | 8'(i));
      chk8("response_mode", 8'(i), {6'h00, response_mode});
      rd(ccr_pkg::MODE_ADDR, 8'(i));
    end
    wr(ccr_pkg::MODE_ADDR, 8'hff);
    rd(ccr_pkg::MODE_ADDR, 8'h33);
    wr(ccr_pkg::MUX_ADDR, 8'ha5);
    chk8("input_select", 8'ha5, {neg_input_select, pos_input_select});
    wr(8'h9c, 8'hff);
    rd(8'h9c, 8'h00);
    rd(ccr_pkg::MUX_ADDR, 8'ha5);
    $display("test fields done");
    wr(ccr_pkg::MODE_ADDR, 8'h20);
    tick(4);
    wr(ccr_pkg::CTRL_ADDR, 8'h80);
    rd(ccr_pkg::CTRL_ADDR, 8'h80);
    pos_above = 1'b1;
    tick(2);
    chk1("comp_raw_out", 1'b1, comp_raw_out);
    chk1("comp_latched_out", 1'b0, comp_latched_out);
    tick(3);
    chk1("comp_latched_out", 1'b1, comp_latched_out);
    chk1("irq_req", 1'b1, irq_req);
    rd(ccr_pkg::CTRL_ADDR, 8'he0);
    wr(ccr_pkg::CTRL_ADDR, 8'h80);
    rd(ccr_pkg::CTRL_ADDR, 8'hc0);
    chk1("irq_req", 1'b0, irq_req);
    pos_above = 1'b0;
    tick(5);
    rd(ccr_pkg::CTRL_ADDR, 8'h90);
    chk1("irq_req", 1'b0, irq_req);
    wr(ccr_pkg::MODE_ADDR, 8'h10);
    chk1("irq_req", 1'b1, irq_req);
    wr(ccr_pkg::CTRL_ADDR, 8'hc0);
    rd(ccr_pkg::CTRL_ADDR, 8'h80);
    chk1("irq_req", 1'b0, irq_req);
    $display("test edges done");
    wr(ccr_pkg::CTRL_ADDR, 8'h00);
    tick(5);
    rd(ccr_pkg::CTRL_ADDR, 8'h00);
    chk1("comp_latched_out", 1'b0, comp_latched_out);
    chk1("comp_raw_out", 1'b0, comp_raw_out);
    clk_en = 1'b0;
    wr(ccr_pkg::MUX_ADDR, 8'h00);
    clk_en = 1'b1;
    rd(ccr_pkg::MUX_ADDR, 8'ha5);
    $display("test disable done");
    // flags set by software, then a reset in mid-run brings every register back
    wr(ccr_pkg::CTRL_ADDR, 8'h3f);
    rd(ccr_pkg::CTRL_ADDR, 8'h3f);
    chk1("irq_req", 1'b1, irq_req);
    sys_rst = 1'b1;
    tick(2);
    sys_rst = 1'b0;
    chk1("irq_req", 1'b0, irq_req);
    rd(ccr_pkg::CTRL_ADDR, 8'h00);
    rd(ccr_pkg::MODE_ADDR, 8'h02);
    rd(ccr_pkg::MUX_ADDR, 8'hff);
    $display("test reset again done");
    tally_and_finish();
  end
endmodule
